// ==== design/pbc_pkg.sv ====
/*
 * Shared constants and types of the push-button power controller.
 * Assumes a 200 MHz system clock; all intervals run on a 1 us internal timebase.
 */
package pbc_pkg;

	// -------------------------------------------------------------------
	// clock and timebase
	// -------------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_NS = 1000;
	localparam int TICK_CYCLES = (TICK_NS * 1000) / CLK_PERIOD_PS;

	// -------------------------------------------------------------------
	// documented intervals, in microseconds, and their timebase counts
	// -------------------------------------------------------------------
	localparam int T_ON_DB_US = 128000;
	localparam int T_OFF_DB_US = 32000;
	localparam int T_KILL_DELAY_US = 128000;
	localparam int T_BLANK_US = 512000;
	localparam int T_LOCKOUT_US = 256000;
	localparam int T_REL_DB_US = 32000;
	localparam int T_KILL_FILT_US = 30;

	localparam int ON_DB_TICKS = (T_ON_DB_US * 1000) / TICK_NS;
	localparam int OFF_DB_TICKS = (T_OFF_DB_US * 1000) / TICK_NS;
	localparam int KILL_DELAY_TICKS = (T_KILL_DELAY_US * 1000) / TICK_NS;
	localparam int BLANK_TICKS = (T_BLANK_US * 1000) / TICK_NS;
	localparam int LOCKOUT_TICKS = (T_LOCKOUT_US * 1000) / TICK_NS;
	localparam int REL_DB_TICKS = (T_REL_DB_US * 1000) / TICK_NS;
	localparam int KILL_FILT_TICKS = (T_KILL_FILT_US * 1000 + TICK_NS - 1) / TICK_NS;

	// -------------------------------------------------------------------
	// widths and reset values
	// -------------------------------------------------------------------
	localparam int TMR_W = 22;
	localparam int FILT_W = 8;
	localparam int EXT_W = 20;
	localparam logic RST_EN_ON = 1'b0;
	localparam logic RST_ALERT_N = 1'b1;

	// extension intervals, each in timebase ticks (1 us)
	typedef struct packed {
		logic [EXT_W-1:0] off_time_extend;
		logic [EXT_W-1:0] shutdown_timeout_extend;
	} pbc_cfg_t;

	// gray-coded along off -> on -> run -> off path
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_ON_DB = 3'h1,
		ST_BLANK = 3'h3,
		ST_ARM = 3'h2,
		ST_RUN = 3'h6,
		ST_OFF_DB = 3'h7,
		ST_ALERT = 3'h5,
		ST_LOCKOUT = 3'h4
	} pbc_state_t;

endpackage : pbc_pkg

// ==== design/pbc_tick_gen.sv ====
/*
 * Timebase prescaler: one-cycle tick every DIV enabled clock cycles.
 * Assumes synchronous active-high reset and a clock enable that freezes it.
 */
`timescale 1ns/100ps
`default_nettype none

module pbc_tick_gen #(
	parameter int DIV = 200
) (
	input wire logic clk_sys, // system clock
	input wire logic srst, // synchronous reset
	input wire logic ce, // clock enable
	output logic tick // one-cycle timebase pulse
);

	localparam int CW = $clog2(DIV);

	initial
	begin
		if (DIV < 2) $error("pbc_tick_gen: DIV must be at least 2");
	end

	logic [CW-1:0] cnt_ff;

	// --------------------------------------------------------------------
	// divider
	// --------------------------------------------------------------------
	// tick is gated by ce so that a frozen block never sees a stale tick
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			cnt_ff <= '0;
		else if (ce)
			cnt_ff <= (cnt_ff == CW'(DIV - 1)) ? '0 : cnt_ff + 1'b1;
	end

	assign tick = ce && (cnt_ff == CW'(DIV - 1));

endmodule : pbc_tick_gen

`default_nettype wire

// ==== design/pbc_power_ctrl.sv ====
/*
 * Push-button on/off power sequencer with host shutdown handshake.
 * Assumes pins push_button_n and shutdown_req_n are asynchronous to clk_sys,
 * and the configuration extensions are static from this clock domain.
 */
//
// Overview of operation
// - ignore button 256ms after shutdown-request release
// - variants differ only in enable polarity
// - base turn-off debounce is 32ms
// - optional extension adds to turn-off debounce
// - 128ms request timeout releases enable itself
// - optional extension lengthens request timeout
// - low request outside blanking drops enable
// - request low pulses under 30us ignored except at blanking end
// - button low 128ms turns enable on
// - 512ms blanking; request still low then releases
// - turn-off debounce raises alert, starts timer
// - button high restarts on and off debounce; button low restarts release debounce
`timescale 1ns/100ps
`default_nettype none

module pbc_power_ctrl
	import pbc_pkg::*;
#(
	parameter bit EN_ACTIVE_HIGH = 1'b1,
	parameter int TICK_DIV = TICK_CYCLES,
	parameter int ON_DB = ON_DB_TICKS,
	parameter int OFF_DB = OFF_DB_TICKS,
	parameter int KILL_DELAY = KILL_DELAY_TICKS,
	parameter int BLANK = BLANK_TICKS,
	parameter int LOCKOUT = LOCKOUT_TICKS,
	parameter int REL_DB = REL_DB_TICKS,
	parameter int KILL_FILT = KILL_FILT_TICKS
) (
	input wire logic clk_sys, // system clock, 200 MHz
	input wire logic srst, // synchronous reset, active high
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic push_button_n, // push button pin, low = pressed
	input wire logic shutdown_req_n, // shutdown request from host, low = request
	input wire pbc_cfg_t cfg, // turn-off and timeout extensions, in ticks
	output logic pwr_en, // power enable, polarity per variant
	output logic alert_n // power-down alert to host, low = alert
);

	initial
	begin
		if (TICK_DIV < 2 || KILL_FILT < 1 || KILL_FILT >= (1 << FILT_W))
			$error("pbc_power_ctrl: timebase or filter setting out of range");
		if (ON_DB < 1 || BLANK < 1 || LOCKOUT < 1 || REL_DB < 1)
			$error("pbc_power_ctrl: intervals must be at least one tick");
		if (OFF_DB + (1 << EXT_W) >= (1 << TMR_W) || KILL_DELAY + (1 << EXT_W) >= (1 << TMR_W))
			$error("pbc_power_ctrl: timer too narrow for extended intervals");
		if (ON_DB >= (1 << TMR_W) || BLANK >= (1 << TMR_W) || LOCKOUT >= (1 << TMR_W))
			$error("pbc_power_ctrl: timer too narrow for fixed intervals");
	end

	// --------------------------------------------------------------------
	// timebase and pin synchronisers
	// --------------------------------------------------------------------
	logic tick;

	pbc_tick_gen #(
		.DIV(TICK_DIV)
	) u_tick (
		.clk_sys(clk_sys),
		.srst(srst),
		.ce(ce),
		.tick(tick)
	);

	logic [1:0] btn_sync_ff;
	logic [1:0] req_sync_ff;

	// two flops per pin; only the second stage is read
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			btn_sync_ff <= 2'h3;
			req_sync_ff <= 2'h3;
		end
		else if (ce)
		begin
			btn_sync_ff <= {btn_sync_ff[0], push_button_n};
			req_sync_ff <= {req_sync_ff[0], shutdown_req_n};
		end
	end

	logic btn_low;
	logic req_low;
	assign btn_low = !btn_sync_ff[1];
	assign req_low = !req_sync_ff[1];

	// --------------------------------------------------------------------
	// shutdown request glitch filter
	// --------------------------------------------------------------------
	logic [FILT_W-1:0] filt_ff;
	logic req_valid_ff;

	// a high level restarts the count, so only a wide low is acted on
	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			filt_ff <= '0;
			req_valid_ff <= 1'b0;
		end
		else if (ce)
		begin
			if (!req_low)
			begin
				filt_ff <= '0;
				req_valid_ff <= 1'b0;
			end
			else if (tick && !req_valid_ff)
			begin
				filt_ff <= filt_ff + 1'b1;
				req_valid_ff <= (filt_ff == FILT_W'(KILL_FILT - 1));
			end
		end
	end

	// --------------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------------
	pbc_state_t state_ff;
	pbc_state_t nxt_state;
	logic [TMR_W-1:0] tmr_ff;
	logic [TMR_W-1:0] target;
	logic done;
	logic restart;

	// interval of the current state; extensions add to the base
	always_comb
	begin
		case (state_ff)
			ST_ON_DB: target = TMR_W'(ON_DB);
			ST_BLANK: target = TMR_W'(BLANK);
			ST_ARM: target = TMR_W'(REL_DB);
			ST_OFF_DB: target = TMR_W'(OFF_DB) + TMR_W'(cfg.off_time_extend);
			ST_ALERT: target = TMR_W'(KILL_DELAY) + TMR_W'(cfg.shutdown_timeout_extend);
			ST_LOCKOUT: target = TMR_W'(LOCKOUT);
			default: target = TMR_W'(1);
		endcase
	end

	assign done = tick && (tmr_ff >= target - 1'b1);

	// request monitored only once blanking is over
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF:
				if (btn_low) nxt_state = ST_ON_DB;
			ST_ON_DB:
				if (!btn_low) nxt_state = ST_OFF;
				else if (done) nxt_state = ST_BLANK;
			ST_BLANK:
				if (done) nxt_state = req_low ? ST_LOCKOUT : ST_ARM;
			ST_ARM:
				if (req_valid_ff) nxt_state = ST_LOCKOUT;
				else if (done) nxt_state = ST_RUN;
			ST_RUN:
				if (req_valid_ff) nxt_state = ST_LOCKOUT;
				else if (btn_low) nxt_state = ST_OFF_DB;
			ST_OFF_DB:
				if (req_valid_ff) nxt_state = ST_LOCKOUT;
				else if (!btn_low) nxt_state = ST_RUN;
				else if (done) nxt_state = ST_ALERT;
			ST_ALERT:
				if (req_valid_ff || done) nxt_state = ST_LOCKOUT;
			ST_LOCKOUT:
				if (done) nxt_state = ST_OFF;
			default:
				nxt_state = ST_OFF;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			state_ff <= ST_OFF;
		else if (ce)
			state_ff <= nxt_state;
	end

	// in the arm state a button press restarts the release debounce
	assign restart = (nxt_state != state_ff) || (state_ff == ST_ARM && btn_low);

	// one counter serves every state interval, all on the same timebase
	always_ff @(posedge clk_sys)
	begin
		if (srst)
			tmr_ff <= '0;
		else if (ce)
		begin
			if (restart)
				tmr_ff <= '0;
			else if (tick && !done)
				tmr_ff <= tmr_ff + 1'b1;
		end
	end

	// --------------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------------
	logic en_on_ff;
	logic alert_n_ff;

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			en_on_ff <= RST_EN_ON;
			alert_n_ff <= RST_ALERT_N;
		end
		else if (ce)
		begin
			en_on_ff <= (nxt_state inside {ST_BLANK, ST_ARM, ST_RUN, ST_OFF_DB, ST_ALERT});
			alert_n_ff <= (nxt_state != ST_ALERT);
		end
	end

	assign pwr_en = EN_ACTIVE_HIGH ? en_on_ff : !en_on_ff;
	assign alert_n = alert_n_ff;

	// --------------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	property p_lockout_holds;
		(ce && state_ff == ST_LOCKOUT && !done) |=> state_ff == ST_LOCKOUT;
	endproperty
	a_lockout_holds: assert property (p_lockout_holds) else $error("lockout left early");

	property p_polarity;
		$rose(en_on_ff) |-> pwr_en == EN_ACTIVE_HIGH;
	endproperty
	a_polarity: assert property (p_polarity) else $error("enable polarity wrong");

	property p_off_db_early;
		(ce && state_ff == ST_OFF_DB && tmr_ff < target - 1'b1) |=> state_ff != ST_ALERT;
	endproperty
	a_off_db_early: assert property (p_off_db_early) else $error("alert before debounce end");

	property p_timeout_release;
		(ce && state_ff == ST_ALERT && done) |=> state_ff == ST_LOCKOUT ##0 !en_on_ff;
	endproperty
	a_timeout_release: assert property (p_timeout_release) else $error("timeout missed");

	property p_req_release;
		(ce && req_valid_ff && state_ff inside {ST_ARM, ST_RUN, ST_OFF_DB, ST_ALERT})
			|=> !en_on_ff && state_ff == ST_LOCKOUT;
	endproperty
	a_req_release: assert property (p_req_release) else $error("request ignored");

	property p_filter;
		(ce && !req_low) |=> !req_valid_ff;
	endproperty
	a_filter: assert property (p_filter) else $error("filter passed a high");

	property p_on_from_db;
		$rose(en_on_ff) |-> $past(state_ff) == ST_ON_DB && $past(btn_low);
	endproperty
	a_on_from_db: assert property (p_on_from_db) else $error("enable without debounce");

	property p_blank_holds;
		(ce && state_ff == ST_BLANK && !done) |=> state_ff == ST_BLANK && en_on_ff;
	endproperty
	a_blank_holds: assert property (p_blank_holds) else $error("blanking broken");

	property p_alert_out;
		state_ff == ST_ALERT |-> !alert_n && en_on_ff;
	endproperty
	a_alert_out: assert property (p_alert_out) else $error("alert not shown");

	property p_db_restart;
		(ce && state_ff == ST_ON_DB && !btn_low) |=> state_ff == ST_OFF && tmr_ff == '0;
	endproperty
	a_db_restart: assert property (p_db_restart) else $error("debounce not restarted");

	property p_reset_state;
		@(posedge clk_sys) disable iff (1'b0) srst |=> !en_on_ff && alert_n && state_ff == ST_OFF;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

	c_power_on: cover property ($rose(en_on_ff));
	c_alert_timeout: cover property (state_ff == ST_ALERT ##1 state_ff == ST_LOCKOUT && req_low == 1'b0);
	c_abort: cover property (state_ff == ST_BLANK ##1 state_ff == ST_LOCKOUT);
	c_host_off: cover property (state_ff == ST_RUN ##1 state_ff == ST_LOCKOUT);

endmodule : pbc_power_ctrl

`default_nettype wire

// ==== sim/pbc_host_model.sv ====
/*
 * host processor model on the far side of the power controller.
 * assumes pwr_on is the active-high enable of the supply that powers it.
 */
`timescale 1ns/100ps
`default_nettype none

module pbc_host_model (
	input wire logic clk_sys, // system clock
	input wire logic pwr_on, // this host's supply is up
	input wire logic alert_n, // power-down alert, low = alert
	input wire logic [1:0] mode, // 0 answers, 1 silent, 2 holds request low
	input wire logic [7:0] delay, // boot and answer delay, cycles
	input wire logic glitch, // bench-commanded short low on the request
	output logic shutdown_req_n // shutdown request, low = request
);
	logic [7:0] boot_ff;
	logic [7:0] ack_ff;
	logic want_low;

	// an unpowered host cannot hold the line up, so it reads low
	assign want_low = glitch || mode == 2'h2 || boot_ff != delay || (mode == 2'h0 && ack_ff == delay);

	// boot within the blanking window, answer the alert after delay
	always_ff @(posedge clk_sys)
	begin
		if (!pwr_on)
		begin
			boot_ff <= 8'h00;
			ack_ff <= 8'h00;
			shutdown_req_n <= 1'b0;
		end
		else
		begin
			if (boot_ff != delay)
				boot_ff <= boot_ff + 8'h01;
			if (!alert_n && ack_ff != delay)
				ack_ff <= ack_ff + 8'h01;
			shutdown_req_n <= !want_low;
		end
	end
endmodule : pbc_host_model

`default_nettype wire

// ==== sim/tb.sv ====
/*
 * self-checking bench for the push-button power controller.
 * assumes shortened timing parameters; both enable polarities run side by side.
 */
`timescale 1ns/100ps
`default_nettype none

module tb;
	import pbc_pkg::*;
	localparam int TD = 2;
	localparam int ON = 8;
	localparam int OFF = 4;
	localparam int KD = 8;
	localparam int BL = 16;
	localparam int LO = 8;
	localparam int RD = 4;
	localparam int KF = 3;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic btn_n = 1'b1;
	logic glitch = 1'b0;
	logic [1:0] mode = 2'h0;
	logic [7:0] dly = 8'h04;
	pbc_cfg_t cfg = '0;
	logic req_n;
	logic pwr_en;
	logic pwr_en_lo;
	logic alert_n;
	logic alert_n_lo;
	int num_errors = 0;
	int checks_done = 0;
	int n;

	always #2.5 clk_sys = ~clk_sys;

	pbc_power_ctrl #(.TICK_DIV(TD), .ON_DB(ON), .OFF_DB(OFF), .KILL_DELAY(KD), .BLANK(BL),
		.LOCKOUT(LO), .REL_DB(RD), .KILL_FILT(KF)) dut (.clk_sys(clk_sys), .srst(srst),
		.ce(ce), .push_button_n(btn_n), .shutdown_req_n(req_n), .cfg(cfg), .pwr_en(pwr_en),
		.alert_n(alert_n));
	pbc_power_ctrl #(.EN_ACTIVE_HIGH(1'b0), .TICK_DIV(TD), .ON_DB(ON), .OFF_DB(OFF),
		.KILL_DELAY(KD), .BLANK(BL), .LOCKOUT(LO), .REL_DB(RD), .KILL_FILT(KF)) dut_lo (
		.clk_sys(clk_sys), .srst(srst), .ce(ce), .push_button_n(btn_n), .shutdown_req_n(req_n),
		.cfg(cfg), .pwr_en(pwr_en_lo), .alert_n(alert_n_lo));
	pbc_host_model host (.clk_sys(clk_sys), .pwr_on(pwr_en), .alert_n(alert_n), .mode(mode),
		.delay(dly), .glitch(glitch), .shutdown_req_n(req_n));

	// ----------------------------
	// compare and wait helpers
	// ----------------------------
	task automatic cmp_bit(input string name, input logic exp, input logic got);
		checks_done++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %b seen %b", name, exp, got);
		end
	endtask : cmp_bit

	task automatic cmp_span(input string name, input int lo, input int hi, input int got);
		checks_done++;
		if (got < lo || got > hi)
		begin
			num_errors++;
			$display("Error %s expected %0d..%0d cycles seen %0d", name, lo, hi, got);
		end
	endtask : cmp_span

	// bounded wait, sampled at the falling edge where outputs are settled
	task automatic wait_sig(input bit sel, input logic v, input int bound, output int cnt);
		cnt = 0;
		// never looks in the launching time step of a rising edge
		do
		begin
			@(negedge clk_sys);
			cnt++;
			if (cnt > bound)
			begin
				num_errors++;
				$display("Error wait sel %0d expected %b seen %b", sel, v, sel ? alert_n : pwr_en);
				end_of_test();
			end
		end
		while ((sel ? alert_n : pwr_en) !== v);
	endtask : wait_sig

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_of_test

	// variants must agree in all but the enable polarity
	always @(negedge clk_sys)
	begin
		if (!srst)
		begin
			cmp_bit("pwr_en_lo", ~pwr_en, pwr_en_lo);
			cmp_bit("alert_n_lo", alert_n, alert_n_lo);
		end
	end

	// ----------------------------
	// scenarios
	// ----------------------------
	task automatic t_power_on();
		@(posedge clk_sys);
		btn_n <= 1'b0;
		repeat (4 * TD) @(posedge clk_sys);
		btn_n <= 1'b1;
		repeat (TD) @(posedge clk_sys);
		btn_n <= 1'b0;
		wait_sig(0, 1'b1, 80, n);
		cmp_span("on debounce", ON * TD - 2, ON * TD + 6, n);
		@(posedge clk_sys);
		btn_n <= 1'b1;
		repeat ((BL + RD) * TD + 8) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp_bit("pwr_en after blank", 1'b1, pwr_en);
	endtask : t_power_on

	task automatic t_glitch();
		@(posedge clk_sys);
		glitch <= 1'b1;
		repeat (TD) @(posedge clk_sys);
		glitch <= 1'b0;
		repeat (10 * TD) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp_bit("pwr_en after short request", 1'b1, pwr_en);
	endtask : t_glitch

	// host answers the alert; button stays down through the lockout
	task automatic t_off_host();
		@(posedge clk_sys);
		cfg <= '{off_time_extend: 20'h00002, shutdown_timeout_extend: 20'h00014};
		btn_n <= 1'b0;
		wait_sig(1, 1'b0, 80, n);
		cmp_span("extended off debounce", (OFF + 2) * TD - 2, (OFF + 2) * TD + 6, n);
		wait_sig(0, 1'b0, 80, n);
		cmp_span("request release", KF * TD, KF * TD + 18, n);
		wait_sig(0, 1'b1, 120, n);
		cmp_span("restart after lockout", (LO + ON) * TD - 2, (LO + ON) * TD + 8, n);
		@(posedge clk_sys);
		btn_n <= 1'b1;
		repeat ((BL + RD) * TD + 8) @(posedge clk_sys);
	endtask : t_off_host

	task automatic t_timeout();
		@(posedge clk_sys);
		mode <= 2'h1;
		cfg <= '{off_time_extend: 20'h00000, shutdown_timeout_extend: 20'h00003};
		btn_n <= 1'b0;
		wait_sig(1, 1'b0, 80, n);
		cmp_span("base off debounce", OFF * TD - 2, OFF * TD + 6, n);
		@(posedge clk_sys);
		btn_n <= 1'b1;
		wait_sig(0, 1'b0, 120, n);
		cmp_span("request timeout", (KD + 3) * TD - 3, (KD + 3) * TD + 4, n);
	endtask : t_timeout

	task automatic t_abort();
		@(posedge clk_sys);
		mode <= 2'h2;
		repeat ((LO + 2) * TD) @(posedge clk_sys);
		btn_n <= 1'b0;
		wait_sig(0, 1'b1, 80, n);
		@(posedge clk_sys);
		btn_n <= 1'b1;
		wait_sig(0, 1'b0, 120, n);
		cmp_span("blank abort", BL * TD - 4, BL * TD + 4, n);
	endtask : t_abort

	// host pulls the request low in normal operation, no alert involved
	task automatic t_host_run_off();
		@(posedge clk_sys);
		mode <= 2'h0;
		repeat ((LO + 2) * TD) @(posedge clk_sys);
		btn_n <= 1'b0;
		wait_sig(0, 1'b1, 80, n);
		@(posedge clk_sys);
		btn_n <= 1'b1;
		repeat ((BL + RD) * TD + 8) @(posedge clk_sys);
		glitch <= 1'b1;
		wait_sig(0, 1'b0, 40, n);
		cmp_span("request release in run", KF * TD + 2, KF * TD + 5, n);
		@(posedge clk_sys);
		glitch <= 1'b0;
	endtask : t_host_run_off

	// clock enable low must freeze the debounce; a mid-run reset drops the enable
	task automatic t_freeze_reset();
		repeat ((LO + 2) * TD) @(posedge clk_sys);
		btn_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		ce <= 1'b0;
		repeat (4 * ON * TD) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp_bit("pwr_en while frozen", 1'b0, pwr_en);
		@(posedge clk_sys);
		ce <= 1'b1;
		wait_sig(0, 1'b1, 80, n);
		cmp_span("on debounce after freeze", ON * TD - 6, ON * TD - 4, n);
		@(posedge clk_sys);
		btn_n <= 1'b1;
		srst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		cmp_bit("pwr_en after mid-run reset", 1'b0, pwr_en);
		cmp_bit("alert_n after mid-run reset", 1'b1, alert_n);
		repeat ((ON + 4) * TD) @(negedge clk_sys);
		cmp_bit("pwr_en idle after reset", 1'b0, pwr_en);
	endtask : t_freeze_reset

	initial
	begin
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		@(negedge clk_sys);
		cmp_bit("pwr_en at reset", 1'b0, pwr_en);
		cmp_bit("alert_n at reset", 1'b1, alert_n);
		t_power_on();
		t_glitch();
		t_off_host();
		t_timeout();
		t_abort();
		t_host_run_off();
		t_freeze_reset();
		end_of_test();
	end
endmodule : tb

`default_nettype wire
